// File: design/ccr_clock_reset.sv
// Purpose: core clock ratio decode, local clock tick, input capture and pin reset control
// Assumes: clock is the core clock; straps are static while powered
// Notes: local_clock_tick marks local clock edges derived from the core clock
//
// limitations a user must know:
// - the local clock is not a real clock here; it is a one-cycle tick
//   inside the core clock domain, so downstream logic stays single-domain
// - half ratios cannot space ticks evenly; they alternate floor and ceil
//   spacing, which keeps the long-run rate exact at the cost of jitter
// - straps are latched only while reset is held; a strap moved later is
//   ignored rather than trusted, since the board promises it never moves
// - an illegal strap setting parks the block in a fault state that only
//   a new reset leaves, with every output pin left undriven
// - pin enables are registered, so pins go quiet on the first edge that
//   sees reset, not combinationally with the reset input itself
//
// Overview of operation
// - synchronise every asynchronous input before use
// - sample every input on a clock edge
// - all output pins undriven from the first clock edge in reset
// - core clock ratio chosen by three-bit strap
// - reset loads the reset state; idle follows on the first edge after release
`timescale 1ns/100ps
module ccr_clock_reset #(
	parameter int unsigned ASYNC_W = 4,
	parameter int unsigned SYNC_W = 4,
	parameter int unsigned PIN_W = 8
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [2:0] core_ratio_strap,
	input wire logic system_clock_freq_strap,
	input wire logic [ASYNC_W-1:0] async_in,
	input wire logic [SYNC_W-1:0] sync_in,
	input wire logic run_request,
	input wire logic [PIN_W-1:0] core_pin_out,
	input wire logic [PIN_W-1:0] core_pin_oe,
	output logic [ASYNC_W-1:0] async_sampled,
	output logic [SYNC_W-1:0] sync_sampled,
	output logic [PIN_W-1:0] pin_out,
	output logic [PIN_W-1:0] pin_oe,
	output logic [3:0] ratio_half,
	output logic ratio_valid,
	output logic strap_fault,
	output logic local_clock_tick,
	output logic core_idle,
	output logic core_running
);
	// refuse widths the logic cannot serve, at elaboration rather than at run time
	if (ASYNC_W < 1 || SYNC_W < 1 || PIN_W < 1) begin : g_width_check
		$error("ccr_clock_reset: widths must be at least one");
	end

	ccr_pkg::ccr_state_t state;
	ccr_pkg::ccr_state_t next_state;
	logic [ASYNC_W-1:0] sync_a;
	logic [ASYNC_W-1:0] sync_b;
	logic [ASYNC_W-1:0] next_sync_a;
	logic [ASYNC_W-1:0] next_sync_b;
	logic [SYNC_W-1:0] next_sync_sampled;
	logic [2:0] ratio_code;
	logic [2:0] next_ratio_code;
	logic freq_ok;
	logic next_freq_ok;
	logic [3:0] next_ratio_half;
	logic next_ratio_valid;
	logic [3:0] tick_cnt;
	logic [3:0] next_tick_cnt;
	logic next_tick;
	logic [PIN_W-1:0] next_pin_out;
	logic [PIN_W-1:0] next_pin_oe;

	// input capture: two flops per asynchronous pin, one for synchronous pins
	// only the second stage is read by anything, so a metastable first stage
	// has a full cycle to settle before its value reaches clocked logic
	// synchronous pins get a single flop: they already meet setup and hold,
	// so a second stage would only add latency
	always_comb begin
		next_sync_a = sys_rst ? '0 : async_in;
		next_sync_b = sys_rst ? '0 : sync_a;
		next_sync_sampled = sys_rst ? '0 : sync_in;
	end

	always_ff @(posedge clock) begin
		sync_a <= next_sync_a;
		sync_b <= next_sync_b;
		sync_sampled <= next_sync_sampled;
	end

	assign async_sampled = sync_b;

	// straps are caught while reset is held, so a late change cannot shift the ratio
	// the last reset edge wins; reset must span at least one edge so the
	// decode below sees a settled code on the first edge after release
	always_comb begin
		next_ratio_code = ratio_code;
		next_freq_ok = freq_ok;
		if (sys_rst) begin
			next_ratio_code = core_ratio_strap;
			next_freq_ok = (system_clock_freq_strap == ccr_pkg::FREQ_STRAP_REQUIRED);
		end
	end

	always_ff @(posedge clock) begin
		ratio_code <= next_ratio_code;
		freq_ok <= next_freq_ok;
	end

	// ratio decode in half units
	// half units keep 2.5 and 3.5 integral, so the tick counter needs no
	// fraction; the reserved code decodes to zero and clears ratio_valid
	always_comb begin
		case (ratio_code)
			3'h0: next_ratio_half = ccr_pkg::HALF_X2;
			3'h1: next_ratio_half = ccr_pkg::HALF_X2P5;
			3'h2: next_ratio_half = ccr_pkg::HALF_X3;
			3'h3: next_ratio_half = ccr_pkg::HALF_X3P5;
			3'h4: next_ratio_half = ccr_pkg::HALF_X4;
			3'h5: next_ratio_half = ccr_pkg::HALF_X5;
			3'h6: next_ratio_half = ccr_pkg::HALF_X6;
			default: next_ratio_half = ccr_pkg::HALF_NONE; // reserved code
		endcase
		next_ratio_valid = (ratio_code != ccr_pkg::RATIO_RESERVED);
		if (sys_rst) begin
			next_ratio_half = ccr_pkg::HALF_NONE;
			next_ratio_valid = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		ratio_half <= next_ratio_half;
		ratio_valid <= next_ratio_valid;
	end

	// control sequence: reset, then idle until software asks to run
	// straps are judged once, in idle, after the decode has settled; a bad
	// strap is fatal until reset because the board cannot fix it while powered
	// run is sticky: only reset returns the core to idle
	always_comb begin
		case (state)
			ccr_pkg::CCR_ST_RESET: begin
				next_state = ccr_pkg::CCR_ST_IDLE;
			end
			ccr_pkg::CCR_ST_IDLE: begin
				if (!ratio_valid || !freq_ok) begin
					next_state = ccr_pkg::CCR_ST_FAULT;
				end else if (run_request) begin
					next_state = ccr_pkg::CCR_ST_RUN;
				end else begin
					next_state = ccr_pkg::CCR_ST_IDLE;
				end
			end
			ccr_pkg::CCR_ST_RUN: next_state = ccr_pkg::CCR_ST_RUN;
			ccr_pkg::CCR_ST_FAULT: next_state = ccr_pkg::CCR_ST_FAULT; // only reset leaves
			default: next_state = ccr_pkg::CCR_ST_RESET;
		endcase
		if (sys_rst) begin
			next_state = ccr_pkg::CCR_ST_RESET;
		end
	end

	always_ff @(posedge clock) begin
		state <= next_state;
	end

	assign core_idle = (state == ccr_pkg::CCR_ST_IDLE);
	assign core_running = (state == ccr_pkg::CCR_ST_RUN);
	assign strap_fault = (state == ccr_pkg::CCR_ST_FAULT);

	// two local periods span 2n core cycles; half ratios alternate floor and ceil spacing
	// the counter runs over one window of 2n cycles and fires at its start and
	// at its midpoint rounded down; with no valid ratio it holds at zero,
	// so no stray tick leaks out of reset or a reserved code
	always_comb begin
		next_tick_cnt = tick_cnt + 4'h1;
		next_tick = 1'b0;
		if (tick_cnt == 4'h0 || tick_cnt == {1'b0, ratio_half[3:1]}) begin
			next_tick = ratio_valid;
		end
		if (tick_cnt >= ratio_half - 4'h1) begin
			next_tick_cnt = ccr_pkg::CNT_RESET;
		end
		if (sys_rst || !ratio_valid) begin
			next_tick_cnt = ccr_pkg::CNT_RESET;
			next_tick = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		tick_cnt <= next_tick_cnt;
		local_clock_tick <= next_tick;
	end

	// output pins: released only while running, so reset and idle leave them floating
	// an undriven pin settles to its pull level; driving zero whenever the state
	// is not run keeps the value net quiet and free of stale data
	always_comb begin
		next_pin_out = core_pin_out;
		next_pin_oe = core_pin_oe;
		if (sys_rst || state != ccr_pkg::CCR_ST_RUN) begin
			next_pin_out = '0;
			next_pin_oe = '0;
		end
	end

	always_ff @(posedge clock) begin
		pin_out <= next_pin_out;
		pin_oe <= next_pin_oe;
	end
endmodule : ccr_clock_reset

// File: design/ccr_pkg.sv
// Purpose: shared constants for the core clock ratio and reset pin block
// Assumes: one clock at 125 MHz, synchronous active-high reset
// Notes: ratios are held in half units so 2.5 and 3.5 stay exact
package ccr_pkg;
	localparam int unsigned CLOCK_MHZ = 125;
	localparam int unsigned RATIO_W = 3;
	localparam int unsigned HALF_W = 4;
	localparam int unsigned SYNC_STAGES = 2;
	// strap codes and their ratios in half units
	localparam logic [2:0] RATIO_DEFAULT = 3'h0;
	localparam logic [2:0] RATIO_RESERVED = 3'h7;
	localparam logic [3:0] HALF_X2 = 4'h4;
	localparam logic [3:0] HALF_X2P5 = 4'h5;
	localparam logic [3:0] HALF_X3 = 4'h6;
	localparam logic [3:0] HALF_X3P5 = 4'h7;
	localparam logic [3:0] HALF_X4 = 4'h8;
	localparam logic [3:0] HALF_X5 = 4'ha;
	localparam logic [3:0] HALF_X6 = 4'hc;
	localparam logic [3:0] HALF_NONE = 4'h0;
	// value the frequency strap must carry
	localparam logic FREQ_STRAP_REQUIRED = 1'h1;
	// values after reset
	localparam logic [3:0] CNT_RESET = 4'h0;
	typedef enum logic [3:0] {
		CCR_ST_RESET = 4'h1,
		CCR_ST_IDLE = 4'h2,
		CCR_ST_RUN = 4'h4,
		CCR_ST_FAULT = 4'h8
	} ccr_state_t;
endpackage : ccr_pkg

// File: tb/ccr_board.sv
// Purpose: board straps
// Assumes: bench changes cfg only in reset
// Notes: plain levels
`timescale 1ns/100ps
module ccr_board (
	input wire logic [3:0] cfg,
	output logic [2:0] core_ratio_strap,
	output logic system_clock_freq_strap
);
	// straps are wires to fixed board levels
	assign core_ratio_strap = cfg[2:0];
	assign system_clock_freq_strap = cfg[3];
endmodule : ccr_board

// File: tb/ccr_props.sv
// Purpose: port checks
// Assumes: one clock
// Notes: reset checks stay live in reset
`timescale 1ns/100ps
module ccr_props #(parameter int unsigned ASYNC_W = 4, SYNC_W = 4, PIN_W = 8) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [2:0] core_ratio_strap,
	input wire logic [ASYNC_W-1:0] async_in,
	input wire logic [ASYNC_W-1:0] async_sampled,
	input wire logic [SYNC_W-1:0] sync_in,
	input wire logic [SYNC_W-1:0] sync_sampled,
	input wire logic [PIN_W-1:0] pin_oe,
	input wire logic ratio_valid,
	input wire logic core_running
);
	default clocking cb @(posedge clock); endclocking
	// sampling delay, reset state, strap decode
	property p_s; disable iff (sys_rst) 1 |=> sync_sampled == $past(sync_in); endproperty
	a_s: assert property (p_s) else $error("sync");
	property p_a; disable iff (sys_rst) 1 |=> ##1 async_sampled == $past(async_in, 2); endproperty
	a_a: assert property (p_a) else $error("async");
	property p_z; sys_rst |=> pin_oe == '0; endproperty
	a_z: assert property (p_z) else $error("pins");
	property p_i; sys_rst |=> !core_running; endproperty
	a_i: assert property (p_i) else $error("idle");
	property p_r; disable iff (sys_rst) !$past(sys_rst) |->
		ratio_valid == (core_ratio_strap != 3'h7); endproperty
	a_r: assert property (p_r) else $error("ratio");
endmodule : ccr_props
bind ccr_clock_reset ccr_props #(.ASYNC_W(ASYNC_W), .SYNC_W(SYNC_W), .PIN_W(PIN_W)) u_p (.clock,
	.sys_rst, .core_ratio_strap, .async_in, .async_sampled, .sync_in, .sync_sampled, .pin_oe,
	.ratio_valid, .core_running);

// File: tb/ccr_tb_top.sv
// Purpose: bench
// Assumes: straps set only in reset
// Notes: inputs move on falling edge
`timescale 1ns/100ps
module core_clock_ratio_reset_pins_tb_top;
	logic clock = 1'h0, sys_rst = 1'h1, run_request = 1'h0;
	logic [3:0] cfg = 4'h8, async_in = 4'h0, sync_in = 4'h0, ratio_half;
	logic [7:0] core_pin_oe = 8'h0, pin_oe, core_pin_out = 8'h0, pin_out;
	logic [3:0] async_sampled, sync_sampled;
	logic strap_fault, local_clock_tick, core_idle;
	logic [2:0] core_ratio_strap;
	logic system_clock_freq_strap, ratio_valid, core_running;
	int fail_count = 0, cmp_count = 0;
	always #4 clock = ~clock;
	// moving pattern keeps the samplers busy
	always @(negedge clock) {async_in, sync_in} <= {async_in, sync_in} + 8'h35;
	ccr_board u_b (.cfg, .core_ratio_strap, .system_clock_freq_strap);
	ccr_clock_reset u_dut (.clock, .sys_rst, .core_ratio_strap, .system_clock_freq_strap,
		.async_in, .sync_in, .run_request, .core_pin_out, .core_pin_oe, .async_sampled,
		.sync_sampled, .pin_out, .pin_oe, .ratio_half, .ratio_valid, .strap_fault,
		.local_clock_tick, .core_idle, .core_running);
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t %h %h", $time, g, e);
		end
	endtask : chk
	task automatic rst(input logic [3:0] c);
		sys_rst = 1'h1;
		cfg = c;
		run_request = 1'h0;
		repeat (3) @(negedge clock);
		chk(16'({core_running, pin_oe}), 16'h0);
		chk(16'({strap_fault, core_idle, pin_out}), 16'h0);
		sys_rst = 1'h0;
	endtask : rst
	task automatic t_ratio;
		logic [3:0] h [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'h0};
		int ticks;
		int gap;
		for (int c = 0; c < 8; c++) begin
			rst(4'h8 | 4'(c));
			repeat (2) @(negedge clock);
			chk(16'({ratio_valid, ratio_half}), 16'({c != 7, h[c]}));
			ticks = 0;
			gap = 0;
			// 840 cycles hold a whole number of 2n windows for every ratio
			repeat (840) begin
				@(negedge clock);
				gap++;
				if (local_clock_tick === 1'h1) begin
					if (ticks > 0)
						chk(16'(gap >= h[c] / 2 && gap <= (h[c] + 1) / 2), 16'h1);
					ticks++;
					gap = 0;
				end
			end
			chk(16'(ticks), (h[c] == 4'h0) ? 16'h0 : 16'(1680 / h[c]));
		end
		$display("ratio done");
	endtask : t_ratio
	task automatic t_run;
		rst(4'h8);
		run_request = 1'h1;
		core_pin_oe = 8'h3c;
		core_pin_out = 8'h5a;
		@(negedge clock);
		chk(16'({core_idle, core_running}), 16'h2);
		repeat (2) @(negedge clock);
		chk(16'({core_running, pin_oe}), 16'h13c);
		chk(16'(pin_out), 16'h5a);
		rst(4'h8);
		$display("run done");
	endtask : t_run
	task automatic t_inputs;
		logic [3:0] prev;
		rst(4'h8);
		@(negedge clock);
		prev = async_in;
		repeat (8) begin
			@(negedge clock);
			chk(16'(sync_sampled), 16'(sync_in));
			chk(16'(async_sampled), 16'(prev));
			prev = async_in;
		end
		$display("inputs done");
	endtask : t_inputs
	task automatic t_fault;
		logic [3:0] bad [2] = '{4'h0, 4'hf};
		for (int i = 0; i < 2; i++) begin
			rst(bad[i]);
			run_request = 1'h1;
			repeat (3) @(negedge clock);
			chk(16'({strap_fault, core_idle, core_running, pin_oe}), 16'h400);
		end
		rst(4'h8);
		$display("fault done");
	endtask : t_fault
	task automatic conclude;
		$display("cmp %0d fail %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	// main sequence
	initial begin
		t_ratio();
		t_inputs();
		t_run();
		t_fault();
		conclude();
	end
endmodule : core_clock_ratio_reset_pins_tb_top
